// ===== smart_card_async_interface.sv
`timescale 1ns/1ns
`default_nettype none
module smart_card_async_interface (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Shared open-drain data line
  input wire logic sd_in,
  output logic sd_out,
  output logic sd_oe,
  // Card clock pin
  output logic sck_out,
  output logic sck_oe
);
  logic [7:0] mode, divisor, ctrl, txd, scmr, port, rxd;
  logic [7:0] next_mode, next_divisor, next_ctrl, next_txd, next_scmr, next_port, next_rxd;
  logic tdre, rdrf, orer, error_signal_status, per, transmit_end_flag;
  logic next_tdre, next_rdrf, next_orer, next_ers, next_per, next_transmit_end_flag;
  logic [7:0] next_rdata;
  smart_card_pkg::tx_state_t tx_state, next_tx_state;
  smart_card_pkg::rx_state_t rx_state, next_rx_state;
  logic [4:0] tx_h, next_tx_h, rx_h, next_rx_h;
  logic [9:0] tx_bits, next_tx_bits;
  logic [8:0] rx_bits, next_rx_bits;
  logic tx_err, next_tx_err;
  logic tx_load, transmit_end_flag_evt, ers_evt, rx_done, realign, pending;
  logic tx_drive, rx_drive, rx_perr_now;
  logic [7:0] rx_line, rx_data;
  logic sck_phase, next_sck_phase, next_sd_oe, next_sck_out, next_sck_oe;
  logic sck_tick, half_etu;
  logic en, gm, odd, te, re, dir, inv, stat_clr;

  function automatic logic [7:0] bit_rev(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction : bit_rev

  // Line-level frame: start, ordered and inverted data, parity over line data bits
  function automatic logic [9:0] tx_frame(input logic [7:0] d, input logic rev, input logic flip,
                                          input logic par_odd);
    logic [7:0] l;
    l = (rev ? bit_rev(d) : d) ^ {8{flip}};
    return {^l ^ par_odd, l, 1'b0};
  endfunction : tx_frame

  assign en = scmr[smart_card_pkg::SCMR_EN];
  assign dir = scmr[smart_card_pkg::SCMR_DIR];
  assign inv = scmr[smart_card_pkg::SCMR_INV];
  assign gm = mode[smart_card_pkg::MODE_GM];
  assign odd = mode[smart_card_pkg::MODE_ODD];
  assign te = ctrl[smart_card_pkg::CTRL_TE];
  assign re = ctrl[smart_card_pkg::CTRL_RE];

  // Only internal timing; no external clock input exists
  smart_card_baud u_baud (
    .clk(clk),
    .resetn(resetn),
    .run(en),
    .realign(realign),
    .cfg({mode[1:0], divisor}),
    .sck_tick(sck_tick),
    .half_etu(half_etu)
  );

  // Transmitter
  always_comb begin
    next_tx_state = tx_state;
    next_tx_h = tx_h;
    next_tx_bits = tx_bits;
    next_tx_err = tx_err;
    tx_load = 1'b0;
    transmit_end_flag_evt = 1'b0;
    ers_evt = 1'b0;
    pending = en && te && !tdre;
    if (half_etu && tx_state == smart_card_pkg::TX_FRAME && tx_h != smart_card_pkg::H_MAX) begin
      next_tx_h = tx_h + 5'h01;
    end
    unique case (tx_state)
      smart_card_pkg::TX_IDLE: begin
        if (half_etu && pending) begin
          tx_load = 1'b1;
        end
      end
      smart_card_pkg::TX_FRAME: begin
        if (half_etu) begin
          // Error window sampled at 11.0 etu, the centre of the pulse
          if (tx_h == smart_card_pkg::H_ERR_SAMPLE && !sd_in) begin
            next_tx_err = 1'b1;
            ers_evt = 1'b1;
          end
          if (gm && tx_h == smart_card_pkg::H_TRANSMIT_END_FLAG_GM1 && sd_in && tdre) begin
            transmit_end_flag_evt = 1'b1;
          end
          if (!gm && tx_h == smart_card_pkg::H_TRANSMIT_END_FLAG_GM0 && !tx_err && tdre) begin
            transmit_end_flag_evt = 1'b1;
          end
          if (tx_err) begin
            if (tx_h == smart_card_pkg::H_RETRY) begin
              next_tx_h = 5'h00;
              next_tx_err = 1'b0;
            end
          end else if (tx_h >= smart_card_pkg::H_GUARD && pending) begin
            tx_load = 1'b1;
          end else if (tx_h == smart_card_pkg::H_TRANSMIT_END_FLAG_GM0) begin
            next_tx_state = smart_card_pkg::TX_IDLE;
          end
        end
      end
    endcase
    if (tx_load) begin
      next_tx_state = smart_card_pkg::TX_FRAME;
      next_tx_h = 5'h00;
      next_tx_bits = tx_frame(txd, dir, inv, odd);
    end
    if (!en || !te) begin
      next_tx_state = smart_card_pkg::TX_IDLE;
      next_tx_err = 1'b0;
    end
  end

  // Drive only zeros; ones and the post-parity time leave the line to the pull-up
  assign tx_drive = tx_state == smart_card_pkg::TX_FRAME && tx_h < smart_card_pkg::H_PARITY_END
                    && !tx_bits[tx_h[4:1]];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_state <= smart_card_pkg::TX_IDLE;
      tx_h <= 5'h00;
      tx_bits <= 10'h3FF;
      tx_err <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_h <= next_tx_h;
      tx_bits <= next_tx_bits;
      tx_err <= next_tx_err;
    end
  end

  // Receiver; during own transmission the etu phase is already aligned (loopback)
  assign rx_perr_now = ^rx_bits ^ odd;
  assign rx_line = rx_bits[7:0] ^ {8{inv}};
  assign rx_data = dir ? bit_rev(rx_line) : rx_line;
  assign rx_drive = rx_state == smart_card_pkg::RX_NACK;

  always_comb begin
    next_rx_state = rx_state;
    next_rx_h = rx_h;
    next_rx_bits = rx_bits;
    rx_done = 1'b0;
    realign = 1'b0;
    if (half_etu && rx_state != smart_card_pkg::RX_IDLE) begin
      next_rx_h = rx_h + 5'h01;
    end
    unique case (rx_state)
      smart_card_pkg::RX_IDLE: begin
        if (en && re && !sd_in) begin
          next_rx_state = smart_card_pkg::RX_FRAME;
          next_rx_h = 5'h00;
          realign = tx_state == smart_card_pkg::TX_IDLE;
        end
      end
      smart_card_pkg::RX_FRAME: begin
        if (half_etu) begin
          if (!rx_h[0] && rx_h <= smart_card_pkg::H_LAST_BIT) begin
            if (rx_h == 5'h00) begin
              if (sd_in) begin
                next_rx_state = smart_card_pkg::RX_IDLE;
              end
            end else begin
              next_rx_bits[rx_h[4:1] - 4'h1] = sd_in;
            end
          end
          if (rx_h == smart_card_pkg::H_RX_EVAL) begin
            rx_done = 1'b1;
          end
          if (rx_h == smart_card_pkg::H_NACK_START) begin
            next_rx_state = rx_perr_now ? smart_card_pkg::RX_NACK : smart_card_pkg::RX_IDLE;
          end
        end
      end
      smart_card_pkg::RX_NACK: begin
        if (half_etu && rx_h == smart_card_pkg::H_NACK_END) begin
          next_rx_state = smart_card_pkg::RX_IDLE;
        end
      end
      default: next_rx_state = smart_card_pkg::RX_IDLE;
    endcase
    if (!en || !re) begin
      next_rx_state = smart_card_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_state <= smart_card_pkg::RX_IDLE;
      rx_h <= 5'h00;
      rx_bits <= 9'h000;
    end else begin
      rx_state <= next_rx_state;
      rx_h <= next_rx_h;
      rx_bits <= next_rx_bits;
    end
  end

  // Status flags: writing 0 clears, transmit_end_flag by a 0 in the TDRE bit; a hardware set in the same cycle wins
  assign stat_clr = wr && addr == smart_card_pkg::OFF_STAT;
  always_comb begin
    next_tdre = (tdre && !(stat_clr && !wdata[smart_card_pkg::STAT_TDRE])) || tx_load;
    next_transmit_end_flag = (transmit_end_flag && !(stat_clr && !wdata[smart_card_pkg::STAT_TDRE])) || transmit_end_flag_evt || (!te && !error_signal_status);
    next_rdrf = (rdrf && !(stat_clr && !wdata[smart_card_pkg::STAT_RDRF])) || rx_done;
    next_orer = (orer && !(stat_clr && !wdata[smart_card_pkg::STAT_ORER])) || (rx_done && rdrf);
    next_ers = (error_signal_status && !(stat_clr && !wdata[smart_card_pkg::STAT_ERS])) || ers_evt;
    next_per = (per && !(stat_clr && !wdata[smart_card_pkg::STAT_PER])) || (rx_done && rx_perr_now);
    next_rxd = (rx_done && !rdrf) ? rx_data : rxd;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tdre <= 1'b1;
      transmit_end_flag <= 1'b1;
      rdrf <= 1'b0;
      orer <= 1'b0;
      error_signal_status <= 1'b0;
      per <= 1'b0;
      rxd <= 8'h00;
    end else begin
      tdre <= next_tdre;
      transmit_end_flag <= next_transmit_end_flag;
      rdrf <= next_rdrf;
      orer <= next_orer;
      error_signal_status <= next_ers;
      per <= next_per;
      rxd <= next_rxd;
    end
  end

  // Configuration registers and read port
  always_comb begin
    next_mode = (wr && addr == smart_card_pkg::OFF_MODE) ? wdata : mode;
    next_divisor = (wr && addr == smart_card_pkg::OFF_DIV) ? wdata : divisor;
    next_ctrl = (wr && addr == smart_card_pkg::OFF_CTRL) ? wdata : ctrl;
    next_txd = (wr && addr == smart_card_pkg::OFF_TXD) ? wdata : txd;
    next_scmr = (wr && addr == smart_card_pkg::OFF_SCMR) ? wdata : scmr;
    next_port = (wr && addr == smart_card_pkg::OFF_PORT) ? wdata : port;
    next_rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        smart_card_pkg::OFF_MODE: next_rdata = mode;
        smart_card_pkg::OFF_DIV: next_rdata = divisor;
        smart_card_pkg::OFF_CTRL: next_rdata = ctrl;
        smart_card_pkg::OFF_TXD: next_rdata = txd;
        smart_card_pkg::OFF_STAT: next_rdata = {tdre, rdrf, orer, error_signal_status, per, transmit_end_flag, 2'b00};
        smart_card_pkg::OFF_RXD: next_rdata = rxd;
        smart_card_pkg::OFF_SCMR: next_rdata = scmr;
        smart_card_pkg::OFF_PORT: next_rdata = port;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode <= smart_card_pkg::MODE_RST;
      divisor <= smart_card_pkg::DIV_RST;
      ctrl <= smart_card_pkg::CTRL_RST;
      txd <= smart_card_pkg::TXD_RST;
      scmr <= smart_card_pkg::SCMR_RST;
      port <= smart_card_pkg::PORT_RST;
      rdata <= 8'h00;
    end else begin
      mode <= next_mode;
      divisor <= next_divisor;
      ctrl <= next_ctrl;
      txd <= next_txd;
      scmr <= next_scmr;
      port <= next_port;
      rdata <= next_rdata;
    end
  end

  // Pins; the clock phase runs free so gating it never changes its duty
  always_comb begin
    next_sck_phase = (en && sck_tick) ? !sck_phase : sck_phase;
    next_sd_oe = en && (tx_drive || rx_drive);
    next_sck_out = port[smart_card_pkg::PORT_SCK_DT];
    next_sck_oe = port[smart_card_pkg::PORT_SCK_IO];
    if (en) begin
      if (ctrl[smart_card_pkg::CTRL_CLOCK_OUT_SEL0]) begin
        next_sck_out = sck_phase;
        next_sck_oe = 1'b1;
      end else if (gm) begin
        next_sck_out = ctrl[smart_card_pkg::CTRL_CLOCK_OUT_SEL1];
        next_sck_oe = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_phase <= 1'b0;
      sd_oe <= 1'b0;
      sd_out <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
    end else begin
      sck_phase <= next_sck_phase;
      sd_oe <= next_sd_oe;
      sd_out <= 1'b0;
      sck_out <= next_sck_out;
      sck_oe <= next_sck_oe;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_start_bit_low: assert property (tx_load && en && te |-> ##2 sd_oe)
    else $error("start bit not driven low");
  a_guard_time: assert property (tx_load && tx_state == smart_card_pkg::TX_FRAME |-> tx_h >= 5'h17)
    else $error("guard time violated");
  a_nack_start: assert property (rx_state == smart_card_pkg::RX_FRAME && half_etu && rx_h == 5'h14
                                 && rx_perr_now && en && re |=> rx_state == smart_card_pkg::RX_NACK ##1 sd_oe)
    else $error("error pulse missing");
  a_nack_release: assert property (rx_state == smart_card_pkg::RX_NACK && half_etu && rx_h == 5'h16
                                   && tx_state == smart_card_pkg::TX_IDLE |-> ##2 !sd_oe)
    else $error("error pulse not released");
  a_retry_same: assert property (tx_err && half_etu && tx_h == 5'h1A && en && te
                                 |=> tx_state == smart_card_pkg::TX_FRAME && tx_h == 5'h00 && $stable(tx_bits))
    else $error("retransmission missing");
  a_line_released: assert property (tx_state == smart_card_pkg::TX_FRAME && tx_h >= 5'h14
                                    && rx_state != smart_card_pkg::RX_NACK |=> !sd_oe)
    else $error("line held after frame");
  a_ers_set: assert property (tx_state == smart_card_pkg::TX_FRAME && half_etu && tx_h == 5'h15
                              && !sd_in |=> error_signal_status)
    else $error("error status not set");
  a_transmit_end_flag_gm1: assert property (tx_state == smart_card_pkg::TX_FRAME && half_etu && gm && tx_h == 5'h15
                               && sd_in && tdre |=> transmit_end_flag)
    else $error("transmit end late in gsm timing");
  a_transmit_end_flag_gm0: assert property (tx_state == smart_card_pkg::TX_FRAME && half_etu && !gm && tx_h == 5'h18
                               && !tx_err && tdre |=> transmit_end_flag)
    else $error("transmit end late in normal timing");
  a_sck_fixed: assert property (en && gm && !ctrl[0] |=> sck_oe && sck_out == $past(ctrl[1]))
    else $error("clock pin level wrong");

  c_frame_done: cover property (tx_state == smart_card_pkg::TX_FRAME ##1 transmit_end_flag);
  c_retry: cover property (tx_err && half_etu && tx_h == 5'h1A);
  c_nack: cover property (rx_state == smart_card_pkg::RX_NACK);
  c_rx_done: cover property (rx_done && !rx_perr_now);
endmodule : smart_card_async_interface
`default_nettype wire

// ===== smart_card_async_interface_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module smart_card_async_interface_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic sd_out, sd_oe, sck_out, sck_oe, card_low;
  logic listen = 1'b0;
  logic nack_en = 1'b0;
  logic send = 1'b0;
  logic [8:0] send_bits = 9'h000;
  logic [8:0] got_bits;
  logic [7:0] got_count, sent_count, v;
  logic [1:0] reply;
  int start_gap, h;
  int n_mismatch = 0;
  int tests_run = 0;
  wire logic sd_in = !(sd_oe && !sd_out) && !card_low;
  always #5 clk = ~clk;
  smart_card_async_interface smart_card_async_interface_inst (.clk(clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe),
    .sck_out(sck_out), .sck_oe(sck_oe));
  smart_card_card_model smart_card_card_model_inst (.clk(clk), .line(sd_in), .pull_low(card_low),
    .listen(listen), .nack_en(nack_en), .send(send), .send_bits(send_bits), .got_bits(got_bits),
    .got_count(got_count), .sent_count(sent_count), .start_gap(start_gap), .reply(reply));
  task conclude;
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  task wait_cnt(input bit sent, input logic [7:0] target);
    int k;
    for (k = 0; k < 30000 && (sent ? sent_count : got_count) !== target; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 30000) chk(8'h00, target);
  endtask : wait_cnt
  task half_period(output int n);
    logic s;
    @(posedge clk);
    #1;
    s = sck_out;
    for (int k = 0; k < 200 && sck_out === s; k++) begin
      @(posedge clk);
      #1;
    end
    #1;
    s = sck_out;
    n = 0;
    while (n < 200 && sck_out === s) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : half_period
  initial begin
    #1000000;
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd_reg(smart_card_pkg::OFF_STAT, v); chk(v, 8'h84);
    rd_reg(smart_card_pkg::OFF_DIV, v); chk(v, smart_card_pkg::DIV_RST);
    rd_reg(smart_card_pkg::OFF_TXD, v); chk(v, smart_card_pkg::TXD_RST);
    wr_reg(smart_card_pkg::OFF_DIV, 8'h00);
    wr_reg(smart_card_pkg::OFF_SCMR, 8'h01);
    wr_reg(smart_card_pkg::OFF_CTRL, 8'h01);
    // Clock pin half period is (divisor+1)*4^n cycles
    for (int p = 0; p < 4; p++) begin
      wr_reg(smart_card_pkg::OFF_MODE, 8'(p));
      half_period(h);
      half_period(h); chk(8'(h), 8'(1 << (2 * p)));
    end
    wr_reg(smart_card_pkg::OFF_MODE, 8'h00);
    wr_reg(smart_card_pkg::OFF_DIV, 8'h02);
    half_period(h);
    half_period(h); chk(8'(h), 8'h03);
    chk({7'h0, sck_oe}, 8'h01);
    wr_reg(smart_card_pkg::OFF_DIV, 8'h00);
    wr_reg(smart_card_pkg::OFF_MODE, 8'h80);
    wr_reg(smart_card_pkg::OFF_CTRL, 8'h02);
    repeat (3) @(posedge clk);
    chk({6'h0, sck_oe, sck_out}, 8'h03);
    wr_reg(smart_card_pkg::OFF_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk({6'h0, sck_oe, sck_out}, 8'h02);
    // Direct transmit of the start character
    wr_reg(smart_card_pkg::OFF_MODE, 8'h28);
    listen <= 1'b1;
    wr_reg(smart_card_pkg::OFF_CTRL, 8'h20);
    wr_reg(smart_card_pkg::OFF_TXD, 8'h3B);
    wr_reg(smart_card_pkg::OFF_STAT, 8'h7F);
    wait_cnt(1'b0, 8'h01);
    chk(got_bits[7:0], 8'h3B);
    chk({7'h0, got_bits[8]}, 8'h01);
    repeat (2300) @(posedge clk);
    rd_reg(smart_card_pkg::OFF_STAT, v); chk(v, 8'h84);
    chk({7'h0, sd_oe}, 8'h00);
    // Card rejects the first copy; the same byte must come again after the guard time
    nack_en <= 1'b1;
    wr_reg(smart_card_pkg::OFF_TXD, 8'hC4);
    wr_reg(smart_card_pkg::OFF_STAT, 8'h7F);
    wait_cnt(1'b0, 8'h02);
    nack_en <= 1'b0;
    wait_cnt(1'b0, 8'h03);
    chk(got_bits[7:0], 8'hC4);
    chk({7'h0, got_bits[8]}, 8'h01);
    chk({7'h0, start_gap >= 12 * 744}, 8'h01);
    rd_reg(smart_card_pkg::OFF_STAT, v); chk(v & 8'h10, 8'h10);
    repeat (4000) @(posedge clk);
    wr_reg(smart_card_pkg::OFF_CTRL, 8'h00);
    wr_reg(smart_card_pkg::OFF_STAT, 8'hEF);
    // Receive with a parity error, then an inverse-convention start character
    listen <= 1'b0;
    wr_reg(smart_card_pkg::OFF_CTRL, 8'h10);
    send_bits <= {1'b1, 8'h5A};
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    wait_cnt(1'b1, 8'h01);
    chk({6'h0, reply}, 8'h03);
    rd_reg(smart_card_pkg::OFF_STAT, v); chk(v & 8'h48, 8'h48);
    rd_reg(smart_card_pkg::OFF_RXD, v); chk(v, 8'h5A);
    wr_reg(smart_card_pkg::OFF_STAT, 8'hB7);
    wr_reg(smart_card_pkg::OFF_CTRL, 8'h00);
    wr_reg(smart_card_pkg::OFF_MODE, 8'h10);
    wr_reg(smart_card_pkg::OFF_SCMR, 8'h0D);
    wr_reg(smart_card_pkg::OFF_CTRL, 8'h10);
    send_bits <= 9'b1_0000_0011;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    wait_cnt(1'b1, 8'h02);
    chk({6'h0, reply}, 8'h02);
    rd_reg(smart_card_pkg::OFF_STAT, v); chk(v & 8'h48, 8'h40);
    rd_reg(smart_card_pkg::OFF_RXD, v); chk(v, 8'h3F);
    // Self-diagnosis: both enables, no card traffic, own frame comes back
    wr_reg(smart_card_pkg::OFF_STAT, 8'hB7);
    wr_reg(smart_card_pkg::OFF_CTRL, 8'h30);
    wr_reg(smart_card_pkg::OFF_TXD, 8'h5A);
    wr_reg(smart_card_pkg::OFF_STAT, 8'h7F);
    repeat (9000) @(posedge clk);
    rd_reg(smart_card_pkg::OFF_STAT, v); chk(v & 8'h48, 8'h40);
    rd_reg(smart_card_pkg::OFF_RXD, v); chk(v, 8'h5A);
    conclude();
  end
endmodule : smart_card_async_interface_tb_top
`default_nettype wire

// ===== smart_card_baud.sv
`timescale 1ns/1ns
`default_nettype none
module smart_card_baud (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic run,
  input wire logic realign,
  input wire smart_card_pkg::baud_cfg_t cfg,
  // Timing pulses
  output logic sck_tick,
  output logic half_etu
);
  logic [14:0] cnt, next_cnt;
  logic [8:0] hc, next_hc;
  logic [14:0] limit;
  logic next_sck_tick, next_half_etu;

  always_comb begin
    // Tick every (N+1)*4^n clocks; 744 ticks make one etu
    limit = 15'(({7'h00, cfg.divisor} + 15'h0001) << {cfg.prescale, 1'b0});
    next_cnt = cnt;
    next_hc = hc;
    next_sck_tick = 1'b0;
    next_half_etu = 1'b0;
    if (!run) begin
      next_cnt = 15'h0000;
      next_hc = 9'h000;
    end else begin
      if (cnt >= limit - 15'h0001) begin
        next_cnt = 15'h0000;
        next_sck_tick = 1'b1;
        if (hc == smart_card_pkg::HALF_ETU_LAST) begin
          next_hc = 9'h000;
          next_half_etu = 1'b1;
        end else begin
          next_hc = hc + 9'h001;
        end
      end else begin
        next_cnt = cnt + 15'h0001;
      end
      // Realign only the etu phase so the card clock duty stays intact
      if (realign) begin
        next_hc = 9'h000;
        next_half_etu = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 15'h0000;
      hc <= 9'h000;
      sck_tick <= 1'b0;
      half_etu <= 1'b0;
    end else begin
      cnt <= next_cnt;
      hc <= next_hc;
      sck_tick <= next_sck_tick;
      half_etu <= next_half_etu;
    end
  end
endmodule : smart_card_baud
`default_nettype wire

// ===== smart_card_card_model.sv
`timescale 1ns/1ns
`default_nettype none
module smart_card_card_model #(parameter int ETU = 744) (
  // Clock
  input wire logic clk,
  // Shared data line
  input wire logic line,
  output logic pull_low,
  // Control
  input wire logic listen,
  input wire logic nack_en,
  input wire logic send,
  input wire logic [8:0] send_bits,
  // Observations
  output logic [8:0] got_bits,
  output logic [7:0] got_count,
  output logic [7:0] sent_count,
  output int start_gap,
  output logic [1:0] reply
);
  logic tx_low = 1'b0;
  logic rx_low = 1'b0;
  logic nk;
  int cyc = 0;
  int last = 0;
  assign pull_low = tx_low | rx_low;
  initial begin
    got_bits = 9'h000;
    got_count = 8'h00;
    sent_count = 8'h00;
    start_gap = 0;
    reply = 2'h0;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Receiver: samples at bit centres, answers every frame with the error pulse while nack_en is set, without checking parity
  always begin
    @(posedge clk iff (listen && !line));
    start_gap = cyc - last;
    last = cyc;
    repeat (ETU / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (ETU) @(posedge clk);
      got_bits[i] = line;
    end
    nk = nack_en;
    got_count = got_count + 8'h01;
    repeat (ETU) @(posedge clk);
    if (nk) begin
      rx_low = 1'b1;
      repeat (ETU) @(posedge clk);
      rx_low = 1'b0;
    end
  end
  // Transmitter: start bit then nine line levels, then release and watch for the error pulse
  always begin
    @(posedge clk iff send);
    for (int i = 0; i < 10; i++) begin
      tx_low = (i == 0) ? 1'b1 : !send_bits[i - 1];
      repeat (ETU) @(posedge clk);
    end
    tx_low = 1'b0;
    repeat (ETU) @(posedge clk);
    reply[0] = !line;
    repeat (ETU) @(posedge clk);
    reply[1] = line;
    sent_count = sent_count + 8'h01;
  end
endmodule : smart_card_card_model
`default_nettype wire

// ===== smart_card_pkg.sv
`default_nettype none
package smart_card_pkg;
  // Register offsets
  localparam logic [2:0] OFF_MODE = 3'h0;
  localparam logic [2:0] OFF_DIV = 3'h1;
  localparam logic [2:0] OFF_CTRL = 3'h2;
  localparam logic [2:0] OFF_TXD = 3'h3;
  localparam logic [2:0] OFF_STAT = 3'h4;
  localparam logic [2:0] OFF_RXD = 3'h5;
  localparam logic [2:0] OFF_SCMR = 3'h6;
  localparam logic [2:0] OFF_PORT = 3'h7;
  // Field positions
  localparam int MODE_GM = 7;
  localparam int MODE_ODD = 4;
  localparam int CTRL_TE = 5;
  localparam int CTRL_RE = 4;
  localparam int CTRL_CLOCK_OUT_SEL1 = 1;
  localparam int CTRL_CLOCK_OUT_SEL0 = 0;
  localparam int STAT_TDRE = 7;
  localparam int STAT_RDRF = 6;
  localparam int STAT_ORER = 5;
  localparam int STAT_ERS = 4;
  localparam int STAT_PER = 3;
  localparam int SCMR_DIR = 3;
  localparam int SCMR_INV = 2;
  localparam int SCMR_EN = 0;
  localparam int PORT_SCK_IO = 3;
  localparam int PORT_SCK_DT = 2;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] TXD_RST = 8'hFF;
  localparam logic [7:0] SCMR_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  // Baud generator: one card clock half period per tick, 372 ticks per half etu
  localparam logic [8:0] HALF_ETU_LAST = 9'h173;
  // Frame timing in half etu counted from the start bit edge
  localparam logic [4:0] H_PARITY_END = 5'h14;
  localparam logic [4:0] H_RX_EVAL = 5'h13;
  localparam logic [4:0] H_NACK_START = 5'h14;
  localparam logic [4:0] H_ERR_SAMPLE = 5'h15;
  localparam logic [4:0] H_NACK_END = 5'h16;
  localparam logic [4:0] H_GUARD = 5'h17;
  localparam logic [4:0] H_TRANSMIT_END_FLAG_GM1 = 5'h15;
  localparam logic [4:0] H_TRANSMIT_END_FLAG_GM0 = 5'h18;
  localparam logic [4:0] H_RETRY = 5'h1A;
  localparam logic [4:0] H_LAST_BIT = 5'h12;
  localparam logic [4:0] H_MAX = 5'h1F;

  typedef enum logic {TX_IDLE, TX_FRAME} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_NACK} rx_state_t;

  typedef struct packed {
    logic [1:0] prescale;
    logic [7:0] divisor;
  } baud_cfg_t;
endpackage : smart_card_pkg
`default_nettype wire
